// >>> dv/aho_gate_logic_tb.sv
module aho_gate_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic io_cyc = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic mem_cyc = 1'b0;
    logic [19:0] mem_addr = 20'h00000;
    logic [2:0] io_jmp = 3'h0;
    logic [1:0] mem_jmp = 2'h0;
    logic lan_req = 1'b0;
    logic lan_irq = 1'b0;
    logic [3:0] other_pull = 4'h0;
    logic irq_mask = 1'b0;
    logic dma_off = 1'b0;
    logic lan_gnt, ext_xcvr_sel;
    logic [3:0] irq_o, irq_oe, irq_line;
    logic [2:0] drq_o, drq_oe, drq_line;
    aho_pkg::aho_io_dec_t io_dec;
    aho_pkg::aho_mem_dec_t mem_dec;
    aho_pkg::aho_buf_req_t buf_req;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] d;
    // bases in jumper order
    logic [15:0] bases [8] = '{16'h0350, 16'h0330, 16'h0310, 16'h0300,
        16'h02e0, 16'h02a0, 16'h0280, 16'h0250};

    aho_gate_logic dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .io_cyc(io_cyc), .io_addr(io_addr), .mem_cyc(mem_cyc), .mem_addr(mem_addr),
        .io_dec(io_dec), .mem_dec(mem_dec), .io_jmp(io_jmp), .mem_jmp(mem_jmp),
        .lan_req(lan_req), .lan_irq(lan_irq), .lan_gnt(lan_gnt), .buf_req(buf_req),
        .buf_rdata(8'h5a), .irq_o(irq_o), .irq_oe(irq_oe), .drq_o(drq_o),
        .drq_oe(drq_oe), .ext_xcvr_sel(ext_xcvr_sel));
    aho_host_model host (.clk(clk), .irq_o(irq_o), .irq_oe(irq_oe), .drq_o(drq_o),
        .drq_oe(drq_oe), .other_pull(other_pull), .irq_mask(irq_mask),
        .dma_off(dma_off), .irq_line(irq_line), .drq_line(drq_line),
        .irq_seen(), .drq_seen());

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // holds the cycle qualifier; decode is read one edge later
    task automatic probe(input logic io, input logic [19:0] a);
        @(posedge clk);
        io_cyc <= io;
        mem_cyc <= !io;
        io_addr <= a[15:0];
        mem_addr <= a;
        tick(1);
    endtask : probe

    task automatic t_reset;
        rd(aho_pkg::REG_CTRL, d);
        chk(d, 8'h08, "ctrl reset");
        rd(aho_pkg::REG_IDC, d);
        chk(d, 8'h00, "idc reset");
        chk(ext_xcvr_sel, 1'b0, "onboard default");
        chk({irq_oe, drq_oe}, 7'h00, "pins released");
        wr(aho_pkg::REG_CTRL, 8'h0a);
        tick(1);
        chk(ext_xcvr_sel, 1'b1, "external xcvr");
        wr(aho_pkg::REG_CTRL, 8'h08);
    endtask : t_reset

    task automatic t_pins;
        for (int i = 0; i < 4; i++)
        begin
            lan_irq <= 1'b1;
            wr(aho_pkg::REG_IDC, 8'h10 << i);
            tick(1);
            chk(irq_oe, 4'h1 << i, "irq enable");
            chk(irq_line[i], 1'b0, "irq sinks");
            lan_irq <= 1'b0;
            other_pull <= 4'h1 << i;
            tick(2);
            chk(irq_oe, 4'h0, "irq released");
            chk(irq_line[i], 1'b0, "shared line");
            other_pull <= 4'h0;
        end
        for (int j = 0; j < 3; j++)
        begin
            wr(aho_pkg::REG_IDC, 8'h02 << j);
            tick(1);
            chk(drq_oe, 3'h1 << j, "drq enable");
            chk(drq_line[j], 1'b0, "drq driven low");
        end
    endtask : t_pins

    task automatic t_soft_reset;
        lan_irq <= 1'b1;
        irq_mask <= 1'b1;
        dma_off <= 1'b1;
        wr(aho_pkg::REG_IDC, 8'h12);
        tick(1);
        chk({irq_oe, drq_oe}, 7'h09, "pins on");
        wr(aho_pkg::REG_CTRL, 8'h09);
        tick(1);
        chk(irq_oe, 4'h0, "irq off");
        chk(drq_oe, 3'h0, "drq float");
        wr(aho_pkg::REG_CTRL, 8'h08);
        lan_irq <= 1'b0;
        irq_mask <= 1'b0;
        dma_off <= 1'b0;
    endtask : t_soft_reset

    task automatic t_decode;
        for (int i = 0; i < 8; i++)
        begin
            io_jmp <= i[2:0];
            tick(3);
            probe(1'b1, {4'h0, bases[i] + 16'h0003});
            chk({io_dec.prom, io_dec.lan, io_dec.prom_idx}, 7'h53, "high prom");
            probe(1'b1, {4'h0, bases[i] + 16'h0402});
            chk(io_dec.gate, 1'b1, "gate decode");
            probe(1'b1, {4'h0, bases[i] + 16'h0010});
            chk({io_dec.lan, io_dec.prom, io_dec.gate}, 3'h0, "outside block");
        end
        wr(aho_pkg::REG_CTRL, 8'h04);
        probe(1'b1, {4'h0, bases[7] + 16'h0005});
        chk({io_dec.prom, io_dec.prom_idx}, 6'h25, "low prom");
        wr(aho_pkg::REG_CTRL, 8'h00);
        tick(1);
        chk({io_dec.lan, io_dec.prom}, 2'b10, "lan window");
        wr(aho_pkg::REG_CTRL, 8'h08);
        probe(1'b0, 20'hdc005);
        chk({mem_dec.ram, mem_dec.eprom, mem_dec.off}, 15'h2005, "eprom");
        wr(aho_pkg::REG_GACFG, 8'h09);
        tick(1);
        chk({mem_dec.ram, mem_dec.eprom}, 2'b10, "ram");
        mem_cyc <= 1'b0;
    endtask : t_decode

    task automatic t_arb;
        @(posedge clk);
        lan_req <= 1'b1;
        tick(1);
        chk(lan_gnt, 1'b1, "lan granted");
        lan_req <= 1'b0;
        tick(2);
        chk(lan_gnt, 1'b0, "lan released");
    endtask : t_arb

    task automatic t_dma;
        wr(aho_pkg::REG_IDC, 8'h02);
        wr(aho_pkg::REG_DMA_HI, 8'h05);
        wr(aho_pkg::REG_DMA_LO, 8'hff);
        wr(aho_pkg::REG_CTRL, 8'h68);
        tick(1);
        chk(drq_line[0], 1'b1, "drq driven high");
        wr(aho_pkg::REG_DATA, 8'ha5);
        tick(1);
        chk(buf_req, {2'b11, 15'h05ff, 8'ha5}, "download write");
        rd(aho_pkg::REG_DMA_HI, d);
        chk(d, 8'h00, "tx area wrap");
        wr(aho_pkg::REG_CTRL, 8'h08);
        wr(aho_pkg::REG_CTRL, 8'h58);
        tick(4);
        rd(aho_pkg::REG_DATA, d);
        chk(d, 8'h5a, "upload through serial fifo");
        wr(aho_pkg::REG_CTRL, 8'h08);
    endtask : t_dma

    initial
    begin
        #100000;
        errors++;
        end_of_test();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_pins();
        t_soft_reset();
        t_decode();
        t_dma();
        t_arb();
        end_of_test();
    end
endmodule : aho_gate_logic_tb

// >>> dv/aho_host_model.sv
module aho_host_model (
    // adapter pins
    input logic clk,
    input logic [3:0] irq_o,
    input logic [3:0] irq_oe,
    input logic [2:0] drq_o,
    input logic [2:0] drq_oe,
    // other adapters and host controller masks
    input logic [3:0] other_pull,
    input logic irq_mask,
    input logic dma_off,
    // resolved lines and host view
    output logic [3:0] irq_line,
    output logic [2:0] drq_line,
    output logic [3:0] irq_seen,
    output logic [2:0] drq_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] float_q = 3'h0;
    // pull-up holds the line high unless some adapter sinks it
    assign irq_line = ~((irq_oe & ~irq_o) | other_pull);
    // undriven line wanders, so a stale level never passes for a drive
    always @(posedge clk) float_q <= ~float_q;
    assign drq_line = (drq_oe & drq_o) | (~drq_oe & float_q);
    // host keeps its controllers quiet across an adapter reset
    assign irq_seen = irq_mask ? 4'h0 : ~irq_line;
    assign drq_seen = dma_off ? 3'h0 : drq_line;
endmodule : aho_host_model

// >>> src/aho_gate_logic.sv
// Notes on behaviour
// - irq pins undriven until channel enabled
// - irq only pulls low, never drives high
// - soft reset releases irq pins
// - irq works dedicated or shared wired-low
// - drq pins undriven until channel enabled
// - enabled drq always driven high or low
// - soft reset floats drq pins
// - control bit 1 picks transceiver, onboard default
// - lan controller wins buffer after current cycle
// - fifo decouples host from lan traffic
// - fifo two 8-deep parallel or 16 serial
// - 8k ram: 1.5k transmit, 6.5k receive
// - shared memory window, gate bit 3 picks
// - 32-byte address prom readable via i/o
// - 16 i/o locations at one of eight bases
// - control bits 2,3 window prom, reset high
// - gate registers at i/o base plus 400h
// - config bits 4-7 enable irq line
// - config bits 1-3 enable drq line
module aho_gate_logic (
    // clock and reset
    input logic clk,
    input logic reset_n,
    // register port
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    // host address decode
    input logic io_cyc,
    input logic [15:0] io_addr,
    input logic mem_cyc,
    input logic [19:0] mem_addr,
    output aho_pkg::aho_io_dec_t io_dec,
    output aho_pkg::aho_mem_dec_t mem_dec,
    // jumper pins
    input logic [2:0] io_jmp,
    input logic [1:0] mem_jmp,
    // lan controller side
    input logic lan_req,
    input logic lan_irq,
    output logic lan_gnt,
    // packet buffer
    output aho_pkg::aho_buf_req_t buf_req,
    input logic [7:0] buf_rdata,
    // host request pins, open drain and tri-state
    output logic [3:0] irq_o,
    output logic [3:0] irq_oe,
    output logic [2:0] drq_o,
    output logic [2:0] drq_oe,
    // transceiver
    output logic ext_xcvr_sel
);
    logic [7:0] ctrl_q, ctrl_d, idc_q, idc_d, gacfg_q, gacfg_d, rdata_q, rdata_d;
    logic [14:0] dma_addr_q, dma_addr_d;
    logic [2:0] io_jmp_s1, io_jmp_s2;
    logic [1:0] mem_jmp_s1, mem_jmp_s2;
    aho_pkg::aho_arb_t arb_q, arb_d;
    aho_pkg::aho_buf_req_t buf_q, buf_d;
    aho_pkg::aho_io_dec_t io_dec_q, io_dec_d;
    aho_pkg::aho_mem_dec_t mem_dec_q, mem_dec_d;
    logic lan_gnt_q, lan_gnt_d, ext_xcvr_q;
    logic [3:0] irq_oe_q, irq_oe_d;
    logic [2:0] drq_o_q, drq_o_d, drq_oe_q, drq_oe_d;
    logic srst, dir, start, serial_q, host_want, host_go, dma_req;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
    logic [7:0] f_in_data, f_out_data;
    logic [15:0] io_base, gate_base;
    logic [14:0] area_top, area_base;

    assign srst = ctrl_q[aho_pkg::CTRL_SRST];
    assign dir = ctrl_q[aho_pkg::CTRL_DIR];
    assign start = ctrl_q[aho_pkg::CTRL_START];

    // jumpers are board straps, resampled before use
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            io_jmp_s1 <= 3'h0;
            io_jmp_s2 <= 3'h0;
            mem_jmp_s1 <= 2'h0;
            mem_jmp_s2 <= 2'h0;
        end
        else
        begin
            io_jmp_s1 <= io_jmp;
            io_jmp_s2 <= io_jmp_s1;
            mem_jmp_s1 <= mem_jmp;
            mem_jmp_s2 <= mem_jmp_s1;
        end
    end

    // staging fifo between host data port and packet buffer
    assign f_in_valid = dir ? (reg_wr && reg_addr == aho_pkg::REG_DATA && start)
                            : (arb_q == aho_pkg::ARB_HOST_D);
    assign f_in_data = dir ? reg_wdata : buf_rdata;
    assign f_out_ready = dir ? host_go : (reg_rd && reg_addr == aho_pkg::REG_DATA);
    // a mode change with data inside would scramble order, so it empties the fifo
    assign f_flush = srst | (serial_q != ctrl_q[aho_pkg::CTRL_FIFO16]);

    aho_stage_fifo #(
        .WIDTH(8),
        .DEPTH(aho_pkg::FIFO_BANK_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(f_flush),
        .serial_mode(ctrl_q[aho_pkg::CTRL_FIFO16]),
        .in_valid(f_in_valid),
        .in_data(f_in_data),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(f_out_data),
        .out_ready(f_out_ready)
    );

    // residual download bytes keep draining after start drops
    assign host_want = !srst && (dir ? f_out_valid : (start && f_in_ready));
    assign dma_req = start && !srst && (dir ? f_in_ready : f_out_valid);

    // transmit and receive areas apply to the 8k ram only
    always_comb
    begin
        if (gacfg_q[aho_pkg::GACFG_RAM8K])
        begin
            area_top = dir ? aho_pkg::TX_END : aho_pkg::RAM8K_TOP;
            area_base = dir ? 15'h0000 : aho_pkg::RX_START;
        end
        else
        begin
            area_top = aho_pkg::RAM32K_TOP;
            area_base = 15'h0000;
        end
    end

    // registers
    always_comb
    begin
        ctrl_d = ctrl_q;
        idc_d = idc_q;
        gacfg_d = gacfg_q;
        dma_addr_d = dma_addr_q;
        rdata_d = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                aho_pkg::REG_CTRL: ctrl_d = reg_wdata;
                aho_pkg::REG_IDC: idc_d = reg_wdata;
                aho_pkg::REG_GACFG: gacfg_d = reg_wdata;
                aho_pkg::REG_DMA_HI: dma_addr_d[14:8] = reg_wdata[6:0];
                aho_pkg::REG_DMA_LO: dma_addr_d[7:0] = reg_wdata;
                default: ;
            endcase
        end
        if (host_go)
            dma_addr_d = (dma_addr_q == area_top) ? area_base : dma_addr_q + 15'h0001;
        if (srst)
            idc_d = aho_pkg::IDC_RESET;
        if (reg_rd)
        begin
            case (reg_addr)
                aho_pkg::REG_CTRL: rdata_d = ctrl_q;
                aho_pkg::REG_IDC: rdata_d = idc_q;
                aho_pkg::REG_GACFG: rdata_d = gacfg_q;
                aho_pkg::REG_DMA_HI: rdata_d = {1'b0, dma_addr_q[14:8]};
                aho_pkg::REG_DMA_LO: rdata_d = dma_addr_q[7:0];
                aho_pkg::REG_DATA: rdata_d = (!dir && f_out_valid) ? f_out_data : 8'h00;
                aho_pkg::REG_STATUS:
                begin
                    rdata_d[aho_pkg::STAT_BUSY] = start | (dir & f_out_valid);
                    rdata_d[aho_pkg::STAT_IN_RDY] = f_in_ready;
                    rdata_d[aho_pkg::STAT_OUT_VLD] = f_out_valid;
                    rdata_d[aho_pkg::STAT_LAN_GNT] = lan_gnt_q;
                    rdata_d[aho_pkg::STAT_EXT_XCVR] = ctrl_q[aho_pkg::CTRL_XCVR];
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_q <= aho_pkg::CTRL_RESET;
            idc_q <= aho_pkg::IDC_RESET;
            gacfg_q <= aho_pkg::GACFG_RESET;
            dma_addr_q <= 15'h0000;
            rdata_q <= 8'h00;
            serial_q <= 1'b0;
            ext_xcvr_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            idc_q <= idc_d;
            gacfg_q <= gacfg_d;
            dma_addr_q <= dma_addr_d;
            rdata_q <= rdata_d;
            serial_q <= ctrl_q[aho_pkg::CTRL_FIFO16];
            ext_xcvr_q <= ctrl_d[aho_pkg::CTRL_XCVR];
        end
    end

    // packet buffer arbiter
    always_comb
    begin
        arb_d = arb_q;
        host_go = 1'b0;
        case (arb_q)
            aho_pkg::ARB_IDLE:
            begin
                if (lan_req)
                    arb_d = aho_pkg::ARB_LAN;
                else if (host_want)
                    arb_d = aho_pkg::ARB_HOST_A;
            end
            aho_pkg::ARB_LAN:
            begin
                if (!lan_req)
                    arb_d = host_want ? aho_pkg::ARB_HOST_A : aho_pkg::ARB_IDLE;
            end
            // a started host cycle always completes
            aho_pkg::ARB_HOST_A: arb_d = aho_pkg::ARB_HOST_D;
            aho_pkg::ARB_HOST_D:
            begin
                if (lan_req)
                    arb_d = aho_pkg::ARB_LAN;
                else if (host_want)
                    arb_d = aho_pkg::ARB_HOST_A;
                else
                    arb_d = aho_pkg::ARB_IDLE;
            end
            default: arb_d = aho_pkg::ARB_IDLE;
        endcase
        if (arb_d == aho_pkg::ARB_HOST_A)
            host_go = 1'b1;
        buf_d = buf_q;
        buf_d.cs = host_go;
        buf_d.we = host_go & dir;
        if (host_go)
        begin
            buf_d.addr = dma_addr_q;
            buf_d.wdata = f_out_data;
        end
        lan_gnt_d = (arb_d == aho_pkg::ARB_LAN);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            arb_q <= aho_pkg::ARB_IDLE;
            buf_q <= '0;
            lan_gnt_q <= 1'b0;
        end
        else
        begin
            arb_q <= arb_d;
            buf_q <= buf_d;
            lan_gnt_q <= lan_gnt_d;
        end
    end

    // request pins
    generate
        for (genvar i = 0; i < aho_pkg::IRQ_LINES; i++)
        begin : g_irq
            // pull low only; the line's pull-up gives the high level
            assign irq_oe_d[i] = idc_q[aho_pkg::IDC_IRQ_LSB + i] & !srst & lan_irq;
        end
        for (genvar j = 0; j < aho_pkg::DRQ_LINES; j++)
        begin : g_drq
            assign drq_oe_d[j] = idc_q[aho_pkg::IDC_DRQ_LSB + j] & !srst;
            assign drq_o_d[j] = dma_req;
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irq_oe_q <= 4'h0;
            drq_oe_q <= 3'h0;
            drq_o_q <= 3'h0;
        end
        else
        begin
            irq_oe_q <= irq_oe_d;
            drq_oe_q <= drq_oe_d;
            drq_o_q <= drq_o_d;
        end
    end

    // host address decode
    assign io_base = aho_pkg::IO_BASES[io_jmp_s2];
    assign gate_base = io_base + aho_pkg::GATE_OFS;

    always_comb
    begin
        io_dec_d = '0;
        if (io_cyc && io_addr[15:4] == io_base[15:4])
        begin
            // window 01 shows prom bytes 0-15, 10 bytes 16-31, else lan registers
            io_dec_d.prom = ctrl_q[aho_pkg::CTRL_WIN_LO] ^ ctrl_q[aho_pkg::CTRL_WIN_HI];
            io_dec_d.lan = !io_dec_d.prom;
            io_dec_d.prom_idx = {ctrl_q[aho_pkg::CTRL_WIN_HI], io_addr[3:0]};
        end
        io_dec_d.gate = io_cyc && io_addr[15:4] == gate_base[15:4];
        mem_dec_d = '0;
        if (mem_cyc && mem_addr[19:13] == aho_pkg::MEM_BASES[mem_jmp_s2][19:13])
        begin
            mem_dec_d.ram = gacfg_q[aho_pkg::GACFG_RAMSEL];
            mem_dec_d.eprom = !gacfg_q[aho_pkg::GACFG_RAMSEL];
            mem_dec_d.off = mem_addr[12:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            io_dec_q <= '0;
            mem_dec_q <= '0;
        end
        else
        begin
            io_dec_q <= io_dec_d;
            mem_dec_q <= mem_dec_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign io_dec = io_dec_q;
    assign mem_dec = mem_dec_q;
    assign lan_gnt = lan_gnt_q;
    assign buf_req = buf_q;
    assign irq_o = 4'h0;
    assign irq_oe = irq_oe_q;
    assign drq_o = drq_o_q;
    assign drq_oe = drq_oe_q;
    assign ext_xcvr_sel = ext_xcvr_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_irq_off_unset: assert property ((idc_q[7:4] == 4'h0) |=> (irq_oe == 4'h0))
        else $error("irq driven while not enabled");
    // a pin may sink only while the lan controller asked for it the cycle before
    a_irq_low_only: assert property (
        (irq_oe != 4'h0) |-> (irq_o == 4'h0 && $past(lan_irq)))
        else $error("irq pin driven high");
    a_irq_srst_off: assert property (srst ##1 srst |-> (irq_oe == 4'h0))
        else $error("irq driven during soft reset");
    a_drq_enabled_driven: assert property (
        (!srst && idc_q[3:1] != 3'h0) |=> (drq_oe == $past(idc_q[3:1])))
        else $error("enabled drq not driven");
    a_drq_srst_float: assert property (srst ##1 srst |-> (drq_oe == 3'h0))
        else $error("drq driven during soft reset");
    a_xcvr_follow: assert property (ext_xcvr_sel == ctrl_q[aho_pkg::CTRL_XCVR])
        else $error("transceiver select does not follow control");
    a_lan_after_cycle: assert property (
        (arb_q == aho_pkg::ARB_HOST_A && lan_req) ##1 lan_req |=> lan_gnt)
        else $error("lan not granted after host cycle");
    a_lan_idle_grant: assert property (
        (arb_q == aho_pkg::ARB_IDLE && lan_req) |=> lan_gnt && !buf_req.cs)
        else $error("lan not granted from idle");
    a_host_next_free: assert property (
        (arb_q == aho_pkg::ARB_IDLE && !lan_req && host_want) |=> buf_req.cs ##1 !buf_req.cs)
        else $error("host cycle not started on free buffer");
    a_prom_reset_win: assert property ($rose(reset_n) |-> ctrl_q[3:2] == 2'b10)
        else $error("reset window not high prom bytes");

endmodule : aho_gate_logic

// >>> src/aho_pkg.sv
package aho_pkg;

    // gate logic register indices on the register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_IDC = 4'h1;
    localparam logic [3:0] REG_GACFG = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_DMA_HI = 4'h5;
    localparam logic [3:0] REG_DMA_LO = 4'h6;

    // control register fields
    localparam int CTRL_SRST = 0;
    localparam int CTRL_XCVR = 1;
    localparam int CTRL_WIN_LO = 2;
    localparam int CTRL_WIN_HI = 3;
    localparam int CTRL_FIFO16 = 4;
    localparam int CTRL_DIR = 5;
    localparam int CTRL_START = 6;
    localparam logic [7:0] CTRL_RESET = 8'h08;

    // int_dma_select_config fields
    localparam int IDC_IRQ_LSB = 4;
    localparam int IDC_DRQ_LSB = 1;
    localparam int IRQ_LINES = 4;
    localparam int DRQ_LINES = 3;
    localparam logic [7:0] IDC_RESET = 8'h00;

    // gate configuration fields
    localparam int GACFG_RAM8K = 0;
    localparam int GACFG_RAMSEL = 3;
    localparam logic [7:0] GACFG_RESET = 8'h01;

    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_IN_RDY = 1;
    localparam int STAT_OUT_VLD = 2;
    localparam int STAT_LAN_GNT = 3;
    localparam int STAT_EXT_XCVR = 4;

    // i/o decode: 16 locations, gate logic at base plus 400h
    localparam logic [15:0] GATE_OFS = 16'h0400;
    localparam logic [7:0][15:0] IO_BASES = {
        16'h0250, 16'h0280, 16'h02a0, 16'h02e0,
        16'h0300, 16'h0310, 16'h0330, 16'h0350};

    // memory window: four 8k locations shared by ram and eprom
    localparam logic [3:0][19:0] MEM_BASES = {
        20'hc8000, 20'hcc000, 20'hd8000, 20'hdc000};

    // packet buffer areas
    localparam logic [14:0] TX_END = 15'h05ff;
    localparam logic [14:0] RX_START = 15'h0600;
    localparam logic [14:0] RAM8K_TOP = 15'h1fff;
    localparam logic [14:0] RAM32K_TOP = 15'h7fff;

    localparam int FIFO_BANK_DEPTH = 8;

    typedef struct packed {
        logic cs;
        logic we;
        logic [14:0] addr;
        logic [7:0] wdata;
    } aho_buf_req_t;

    typedef struct packed {
        logic lan;
        logic prom;
        logic gate;
        logic [4:0] prom_idx;
    } aho_io_dec_t;

    typedef struct packed {
        logic ram;
        logic eprom;
        logic [12:0] off;
    } aho_mem_dec_t;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_LAN = 2'b01,
        ARB_HOST_A = 2'b10,
        ARB_HOST_D = 2'b11
    } aho_arb_t;

endpackage : aho_pkg

// >>> src/aho_stage_fifo.sv
module aho_stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = aho_pkg::FIFO_BANK_DEPTH
) (
    // clock and reset
    input logic clk,
    input logic reset_n,
    // mode
    input logic flush,
    input logic serial_mode,
    // fill side
    input logic in_valid,
    input logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input logic out_ready
);
    // depth must be a power of two so the pointers wrap by overflow
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [1:0] push;
    logic [1:0] pop;
    logic [1:0] nfull;
    logic [1:0] nempty;
    logic [WIDTH-1:0] din [2];
    logic [WIDTH-1:0] head [2];
    logic wsel_q, wsel_d, rsel_q, rsel_d;

    generate
        for (genvar b = 0; b < 2; b++)
        begin : g_bank
            logic [WIDTH-1:0] mem [DEPTH];
            logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
            logic [CW-1:0] cnt_q, cnt_d;

            assign head[b] = mem[rp_q];
            assign nfull[b] = (cnt_q != FULL);
            assign nempty[b] = (cnt_q != '0);

            always_comb
            begin
                wp_d = wp_q;
                rp_d = rp_q;
                cnt_d = cnt_q;
                if (flush)
                begin
                    wp_d = '0;
                    rp_d = '0;
                    cnt_d = '0;
                end
                else
                begin
                    if (push[b])
                        wp_d = wp_q + 1'b1;
                    if (pop[b])
                        rp_d = rp_q + 1'b1;
                    cnt_d = cnt_q + CW'(push[b]) - CW'(pop[b]);
                end
            end

            always_ff @(posedge clk)
            begin
                if (!reset_n)
                begin
                    wp_q <= '0;
                    rp_q <= '0;
                    cnt_q <= '0;
                end
                else
                begin
                    wp_q <= wp_d;
                    rp_q <= rp_d;
                    cnt_q <= cnt_d;
                end
            end

            always_ff @(posedge clk)
            begin
                if (push[b] && !flush)
                    mem[wp_q] <= din[b];
            end
        end
    endgenerate

    always_comb
    begin
        push = 2'b00;
        pop = 2'b00;
        din[0] = in_data;
        din[1] = in_data;
        wsel_d = wsel_q;
        rsel_d = rsel_q;
        if (serial_mode)
        begin
            // one 16-deep queue: bank 0 feeds bank 1 every cycle it can
            in_ready = nfull[0];
            push[0] = in_valid & nfull[0];
            push[1] = nempty[0] & nfull[1];
            pop[0] = push[1];
            din[1] = head[0];
            out_valid = nempty[1];
            out_data = head[1];
            pop[1] = nempty[1] & out_ready;
        end
        else
        begin
            // two 8-deep banks side by side, bytes alternate between them
            in_ready = nfull[wsel_q];
            push[wsel_q] = in_valid & nfull[wsel_q];
            if (in_valid && nfull[wsel_q])
                wsel_d = ~wsel_q;
            out_valid = nempty[rsel_q];
            out_data = head[rsel_q];
            pop[rsel_q] = nempty[rsel_q] & out_ready;
            if (nempty[rsel_q] && out_ready)
                rsel_d = ~rsel_q;
        end
        if (flush)
        begin
            wsel_d = 1'b0;
            rsel_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wsel_q <= 1'b0;
            rsel_q <= 1'b0;
        end
        else
        begin
            wsel_q <= wsel_d;
            rsel_q <= rsel_d;
        end
    end

endmodule : aho_stage_fifo
